// ---- verilog/fbl_pkg.sv ----
// shared constants and types of the flash boot loader
// assumes a 200 MHz system clock and a plain serial flash on quad pins
package fbl_pkg;

  // timing
  localparam int CLK_MHZ = 200;
  localparam int RING_OSC_KHZ = 6500;
  localparam int ATTEMPT_TIME_US = 4000;
  localparam int ATTEMPT_CYC = ATTEMPT_TIME_US * CLK_MHZ;
  localparam int ATTEMPT_COUNT = 128;
  localparam logic [3:0] SCK_HALF_BASE = 4'h2;

  // xip exit sequence
  localparam logic [11:0] EXIT_LONG_CLKS = 12'h020;
  localparam logic [11:0] EXIT_SHORT_CLKS = 12'h010;
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_UP = 2'h1;
  localparam logic [1:0] PULL_DOWN = 2'h2;
  localparam logic [3:0] IO_OE_MOSI = 4'h1;

  // serial read of the second stage
  localparam logic [7:0] READ_CMD = 8'h03;
  localparam logic [23:0] READ_ADDR = 24'h000000;
  localparam logic [11:0] CMD_BITS = 12'h020;
  localparam logic [11:0] LAST_BIT = 12'h81F;
  localparam logic [7:0] PAYLOAD_BYTES = 8'hFC;

  // checksum
  localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_XOROUT = 32'h00000000;

  // warm boot
  localparam logic [31:0] WD_MAGIC = 32'hB007C0D3;

  // second core launch words
  localparam logic [31:0] LAUNCH_ZERO = 32'h00000000;
  localparam logic [31:0] LAUNCH_ONE = 32'h00000001;

  typedef enum logic [4:0] {
    ST_HOLD, ST_OSC, ST_RELEASE, ST_RESCUE, ST_WDOG, ST_BUTTON,
    ST_PADCFG, ST_EXIT1, ST_EXIT2, ST_GAP1, ST_EXIT3, ST_GAP2,
    ST_XFER, ST_CHECK, ST_RETRY, ST_EXEC, ST_USB, ST_HALT, ST_DONE
  } fbl_state_t;

  typedef struct packed {
    logic [31:0] sp;
    logic [31:0] pc;
  } fbl_jump_t;

  typedef struct packed {
    logic run_s1, run_s2, csn_s1, csn_s2, io1_s1, io1_s2;
    logic resc_s1, resc_s2, osc_s1, osc_s2;
    fbl_state_t st;
    logic [3:0] div;
    logic sclk;
    logic [11:0] edge_cnt;
    logic [31:0] shift;
    logic [7:0] byte_sh;
    logic [31:0] crc;
    logic [31:0] chk;
    logic [6:0] attempt;
    logic [19:0] timer;
    logic released, pad_cfg, usb, halt, exec, xip_ok, wd_jump;
    logic scr4_clr, resc_clr;
    fbl_jump_t jump;
    logic sram_we;
    logic [7:0] sram_addr;
    logic [7:0] sram_data;
    logic c1_sleep, c1_run, echo_v;
    logic [2:0] c1_seq;
    logic [31:0] echo_d;
    logic [31:0] c1_vector_table_offset;
    fbl_jump_t c1_jump;
  } fbl_regs_t;

  localparam fbl_regs_t FBL_RESET_STATE = '0;

endpackage

// ---- verilog/fbl_boot_loader.sv ----
// boot sequencer: power-on release, rescue, warm boot, flash load, launch
// assumes flash pins pass through pads outside; sram and fifo are same clock
//
// Functional notes
// - chip-enable pin low holds everything in reset, no boot activity.
// - start ring oscillator first; clocks run slowly near 6.5MHz.
// - once clocks run, release subsystems from reset; both cores start.
// - second core sleeps waiting for event until woken via mailbox.
// - rescue power-up: clear rescue flag and halt immediately.
// - warm boot: scratch4 equals magic, scratch5 equals entry xor magic.
// - mismatch skips warm boot; match clears scratch4 then jumps.
// - flash select pin tied low skips flash boot, go USB boot.
// - set pad muxing and single-bit SPI mode before the exit sequence.
// - exit: select high pulled 0000 32 clocks, select low pulled 1111.
// - then deselect, reselect, drive data-out high 16 clocks, others hi-Z.
// - read 256 bytes with command 03h into the boot sram bank.
// - last four bytes: little-endian CRC32 of first 252 bytes.
// - CRC poly 04C11DB7, unreflected, init all ones, no final xor.
// - up to 128 attempts of about 4ms varying SPI, then USB.
// - on CRC pass start executing the payload at once.
// - no execute-in-place window access before second stage configures it.
// - launch words 0,0,1,vector_table_offset,sp,entry echoed; mismatch restarts sequence.
// - launch handshake accepted from subsystem release until the second core runs, even asleep.
`timescale 1ns/1ps
module fbl_boot_loader
  import fbl_pkg::*;
#(
  parameter int ATTEMPT_CYCLES = fbl_pkg::ATTEMPT_CYC,
  parameter int ATTEMPTS = fbl_pkg::ATTEMPT_COUNT
)(
  // clock, reset, enable
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  // power-on and reset sequencing
  input wire logic run_pin_in,
  input wire logic osc_stable_in,
  output logic osc_start_out,
  output logic subsys_release_out,
  // boot source selection
  input wire logic rescue_flag_in,
  output logic rescue_clear_out,
  output logic halt_out,
  input wire logic [31:0] scratch4_in,
  input wire logic [31:0] scratch5_in,
  input wire logic [31:0] scratch6_in,
  input wire logic [31:0] scratch7_in,
  output logic scratch4_clear_out,
  output logic wd_jump_out,
  output fbl_pkg::fbl_jump_t wd_target_out,
  output logic usb_boot_out,
  // serial flash pins
  output logic pad_cfg_out,
  output logic spi_std_mode_out,
  output logic flash_sclk_out,
  output logic flash_select_n_out,
  input wire logic flash_select_n_in,
  output logic [3:0] flash_io_lines_out,
  output logic [3:0] flash_io_lines_oe_out,
  input wire logic [3:0] flash_io_lines_in,
  output logic [1:0] flash_io_pull_out,
  // boot sram bank write port
  output logic sram_we_out,
  output logic [7:0] sram_addr_out,
  output logic [7:0] sram_data_out,
  // second stage hand-off
  output logic exec_sram_out,
  input wire logic stage2_cfg_done_in,
  output logic xip_enable_out,
  // second core mailbox
  input wire logic fifo_in_valid_in,
  input wire logic [31:0] fifo_in_data_in,
  output logic fifo_in_ready_out,
  output logic fifo_out_valid_out,
  output logic [31:0] fifo_out_data_out,
  input wire logic fifo_out_ready_in,
  input wire logic wake_event_in,
  output logic deep_sleep_select_out,
  output logic core1_run_out,
  output logic [31:0] core1_vector_table_offset_out,
  output fbl_pkg::fbl_jump_t core1_target_out
);
  import fbl_pkg::*;

  localparam logic [19:0] ATT_LOAD = 20'(ATTEMPT_CYCLES - 1);
  localparam logic [6:0] ATT_LAST = 7'(ATTEMPTS - 1);

  fbl_regs_t q, d;
  logic timed, sck_run, tick, rise, fall;
  logic [3:0] half;

  // msb first, unreflected; final xor folded in at compare
  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0] b);
    logic [31:0] r;
    r = c;
    for (int i = 7; i >= 0; i--)
    begin
      if (r[31] ^ b[i])
        r = {r[30:0], 1'b0} ^ CRC_POLY;
      else
        r = {r[30:0], 1'b0};
    end
    return r;
  endfunction

  function automatic logic in_exit(input fbl_state_t s);
    return (s == ST_EXIT1) || (s == ST_EXIT2) || (s == ST_EXIT3);
  endfunction

  always_comb
  begin
    d = q;
    d.run_s1 = run_pin_in;
    d.run_s2 = q.run_s1;
    d.csn_s1 = flash_select_n_in;
    d.csn_s2 = q.csn_s1;
    d.io1_s1 = flash_io_lines_in[1];
    d.io1_s2 = q.io1_s1;
    d.resc_s1 = rescue_flag_in;
    d.resc_s2 = q.resc_s1;
    d.osc_s1 = osc_stable_in;
    d.osc_s2 = q.osc_s1;
    d.scr4_clr = 1'b0;
    d.resc_clr = 1'b0;
    d.sram_we = 1'b0;

    // clock divider; the half period steps with the low two bits of the attempt number
    sck_run = in_exit(q.st) || (q.st == ST_XFER);
    timed = sck_run || (q.st == ST_GAP1) || (q.st == ST_GAP2);
    half = SCK_HALF_BASE + {2'h0, q.attempt[1:0]};
    tick = timed && (q.div == 4'h0);
    rise = sck_run && tick && !q.sclk;
    fall = sck_run && tick && q.sclk;
    d.div = !timed ? 4'h0 : (tick ? half : q.div - 4'h1);
    d.sclk = sck_run ? (q.sclk ^ tick) : 1'b0;
    if (q.timer != 20'h0)
      d.timer = q.timer - 20'h1;

    unique case (q.st)
      ST_HOLD:
        d.st = ST_OSC;
      ST_OSC:
        if (q.osc_s2)
          d.st = ST_RELEASE;
      ST_RELEASE:
      begin
        d.released = 1'b1;
        d.c1_sleep = 1'b1;
        d.st = ST_RESCUE;
      end
      ST_RESCUE:
        if (q.resc_s2)
        begin
          d.resc_clr = 1'b1;
          d.halt = 1'b1;
          d.st = ST_HALT;
        end
        else
          d.st = ST_WDOG;
      ST_WDOG:
        if (scratch4_in == WD_MAGIC &&
            scratch5_in == (scratch7_in ^ WD_MAGIC))
        begin
          d.scr4_clr = 1'b1;
          d.wd_jump = 1'b1;
          d.jump.sp = scratch6_in;
          d.jump.pc = scratch7_in;
          d.st = ST_DONE;
        end
        else
          d.st = ST_BUTTON;
      ST_BUTTON:
        if (!q.csn_s2)
        begin
          d.usb = 1'b1;
          d.st = ST_USB;
        end
        else
          d.st = ST_PADCFG;
      ST_PADCFG:
      begin
        d.pad_cfg = 1'b1;
        d.timer = ATT_LOAD;
        d.edge_cnt = 12'h0;
        d.st = ST_EXIT1;
      end
      ST_EXIT1, ST_EXIT2, ST_EXIT3:
        if (fall)
        begin
          d.edge_cnt = q.edge_cnt + 12'h1;
          if (q.st != ST_EXIT3 &&
              q.edge_cnt == EXIT_LONG_CLKS - 12'h1)
          begin
            d.edge_cnt = 12'h0;
            d.st = (q.st == ST_EXIT1) ? ST_EXIT2 : ST_GAP1;
          end
          if (q.st == ST_EXIT3 &&
              q.edge_cnt == EXIT_SHORT_CLKS - 12'h1)
            d.st = ST_GAP2;
        end
      ST_GAP1:
        if (tick)
          d.st = ST_EXIT3;
      ST_GAP2:
        if (tick)
        begin
          d.st = ST_XFER;
          d.edge_cnt = 12'h0;
          d.shift = {READ_CMD, READ_ADDR};
          d.crc = CRC_INIT;
        end
      ST_XFER:
      begin
        if (fall)
          d.shift = {q.shift[30:0], 1'b0};
        if (rise)
        begin
          d.edge_cnt = q.edge_cnt + 12'h1;
          if (q.edge_cnt >= CMD_BITS)
          begin
            d.byte_sh = {q.byte_sh[6:0], q.io1_s2};
            if (q.edge_cnt[2:0] == 3'h7)
            begin
              d.sram_we = 1'b1;
              d.sram_addr = 8'((q.edge_cnt - CMD_BITS) >> 3);
              d.sram_data = d.byte_sh;
              if (d.sram_addr < PAYLOAD_BYTES)
                d.crc = crc_byte(q.crc, d.byte_sh);
              else
                d.chk = {d.byte_sh, q.chk[31:8]};
            end
          end
          if (q.edge_cnt == LAST_BIT)
            d.st = ST_CHECK;
        end
      end
      ST_CHECK:
        if ((q.crc ^ CRC_XOROUT) == q.chk)
        begin
          d.exec = 1'b1;
          d.st = ST_EXEC;
        end
        else
          d.st = ST_RETRY;
      ST_RETRY:
        if (q.timer == 20'h0)
        begin
          if (q.attempt == ATT_LAST)
          begin
            d.usb = 1'b1;
            d.st = ST_USB;
          end
          else
          begin
            d.attempt = q.attempt + 7'h1;
            d.timer = ATT_LOAD;
            d.edge_cnt = 12'h0;
            d.st = ST_EXIT1;
          end
        end
      ST_EXEC:
        if (stage2_cfg_done_in)
          d.xip_ok = 1'b1;
      ST_USB, ST_HALT, ST_DONE:
        d.st = q.st;
    endcase

    // second core mailbox; words are taken whether it sleeps or not
    if (q.echo_v && fifo_out_ready_in)
    begin
      d.echo_v = 1'b0;
      d.c1_sleep = !q.c1_run;
    end
    if (q.released && wake_event_in)
      d.c1_sleep = 1'b0;
    if (fifo_in_valid_in && fifo_in_ready_out)
    begin
      d.c1_sleep = 1'b0;
      d.echo_v = 1'b1;
      d.echo_d = fifo_in_data_in;
      d.c1_seq = 3'h0;
      unique case (q.c1_seq)
        3'h0, 3'h1:
          if (fifo_in_data_in == LAUNCH_ZERO)
            d.c1_seq = q.c1_seq + 3'h1;
        3'h2:
          if (fifo_in_data_in == LAUNCH_ONE)
            d.c1_seq = 3'h3;
        3'h3:
        begin
          d.c1_vector_table_offset = fifo_in_data_in;
          d.c1_seq = 3'h4;
        end
        3'h4:
        begin
          d.c1_jump.sp = fifo_in_data_in;
          d.c1_seq = 3'h5;
        end
        default:
        begin
          d.c1_jump.pc = fifo_in_data_in;
          d.c1_run = 1'b1;
        end
      endcase
    end

    // run pin low: everything but the run pin synchroniser back to reset
    if (!q.run_s2)
    begin
      d = FBL_RESET_STATE;
      d.run_s1 = run_pin_in;
      d.run_s2 = q.run_s1;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
      q <= FBL_RESET_STATE;
    else if (clk_en_in)
      q <= d;
  end

  // outputs
  assign osc_start_out = q.run_s2 && (q.st != ST_HOLD);
  assign subsys_release_out = q.released;
  assign rescue_clear_out = q.resc_clr;
  assign halt_out = q.halt;
  assign scratch4_clear_out = q.scr4_clr;
  assign wd_jump_out = q.wd_jump;
  assign wd_target_out = q.jump;
  assign usb_boot_out = q.usb;
  assign pad_cfg_out = q.pad_cfg;
  assign spi_std_mode_out = q.pad_cfg;
  assign flash_sclk_out = q.sclk;
  assign flash_select_n_out = !((q.st == ST_EXIT2) || (q.st == ST_EXIT3) ||
                                (q.st == ST_XFER));
  assign flash_io_lines_oe_out = ((q.st == ST_EXIT3) || (q.st == ST_XFER)) ?
                                 IO_OE_MOSI : 4'h0;
  assign flash_io_lines_out = {3'h0, (q.st == ST_EXIT3) | q.shift[31]};
  assign flash_io_pull_out = (q.st == ST_EXIT1) ? PULL_DOWN :
                             (q.st == ST_EXIT2) ? PULL_UP : PULL_NONE;
  assign sram_we_out = q.sram_we;
  assign sram_addr_out = q.sram_addr;
  assign sram_data_out = q.sram_data;
  assign exec_sram_out = q.exec;
  assign xip_enable_out = q.xip_ok;
  assign fifo_in_ready_out = q.released && !q.echo_v && !q.c1_run;
  assign fifo_out_valid_out = q.echo_v;
  assign fifo_out_data_out = q.echo_d;
  assign deep_sleep_select_out = q.c1_sleep;
  assign core1_run_out = q.c1_run;
  assign core1_vector_table_offset_out = q.c1_vector_table_offset;
  assign core1_target_out = q.c1_jump;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in || !clk_en_in);

  sequence s_exit1_done;
    q.st == ST_EXIT1 && fall && q.edge_cnt == EXIT_LONG_CLKS - 12'h1;
  endsequence
  sequence s_exit2_done;
    q.st == ST_EXIT2 && fall && q.edge_cnt == EXIT_LONG_CLKS - 12'h1;
  endsequence

  a_run_low_hold: assert property (
    !q.run_s2 |=> q.st == ST_HOLD && !subsys_release_out && !exec_sram_out)
    else $error("run pin low did not hold boot in reset");
  a_osc_before_release: assert property (
    $rose(subsys_release_out) |-> osc_start_out && $past(q.st) == ST_RELEASE)
    else $error("release without running oscillator");
  a_rescue_halt_now: assert property (
    q.st == ST_RESCUE && q.resc_s2 && q.run_s2
      |=> rescue_clear_out && halt_out ##1 !rescue_clear_out && halt_out)
    else $error("rescue did not clear flag and halt");
  a_wdog_clear_jump: assert property (
    scratch4_clear_out |-> wd_jump_out && $past(scratch4_in) == WD_MAGIC)
    else $error("scratch4 cleared without magic match");
  a_button_to_usb: assert property (
    q.st == ST_BUTTON && !q.csn_s2 && q.run_s2 |=> usb_boot_out
      && flash_select_n_out && !pad_cfg_out)
    else $error("tied select did not skip flash boot");
  a_exit_phase_pins: assert property (
    q.st == ST_EXIT1 |-> flash_select_n_out && flash_io_pull_out == PULL_DOWN
      && flash_io_lines_oe_out == 4'h0 && pad_cfg_out)
    else $error("first exit phase pins wrong");
  a_exit_phase_step: assert property (
    s_exit1_done and q.run_s2 |=> q.st == ST_EXIT2 && !flash_select_n_out
      && flash_io_pull_out == PULL_UP)
    else $error("exit phase one did not last 32 clocks");
  a_exit_gap: assert property (
    s_exit2_done and q.run_s2 |=> flash_select_n_out ##[1:8] q.st == ST_EXIT3)
    else $error("select not dropped between exit phases");
  a_mosi_drive: assert property (
    q.st == ST_EXIT3 |-> !flash_select_n_out && flash_io_lines_oe_out == 4'h1
      && flash_io_lines_out[0])
    else $error("data-out not driven high in last phase");
  a_exec_on_pass: assert property (
    $rose(exec_sram_out) |-> $past(q.st) == ST_CHECK
      && $past(q.crc) == $past(q.chk))
    else $error("execution started without checksum pass");
  a_usb_after_all: assert property (
    $rose(usb_boot_out) && $past(q.st) == ST_RETRY
      |-> $past(q.attempt) == ATT_LAST)
    else $error("fell back to usb before last attempt");
  a_xip_gate: assert property (
    xip_enable_out |-> exec_sram_out)
    else $error("xip window opened before second stage");
  a_echo_word: assert property (
    fifo_in_valid_in && fifo_in_ready_out && q.run_s2
      |=> fifo_out_valid_out && fifo_out_data_out == $past(fifo_in_data_in))
    else $error("mailbox word not echoed");
  a_launch_restart: assert property (
    fifo_in_valid_in && fifo_in_ready_out && q.run_s2 && q.c1_seq < 3'h2
      && fifo_in_data_in != LAUNCH_ZERO |=> q.c1_seq == 3'h0)
    else $error("bad launch word did not restart");
endmodule

// ---- dv/fbl_flash_model.sv ----
// serial flash model answering plain 03h reads from a fixed 256-byte image
// assumes the loader makes clock and select; pulls and bus are resolved here
`timescale 1ns/1ps
module fbl_flash_model (
  // control from the bench
  input wire logic rst_in,
  input wire logic corrupt_in,
  // flash pins
  input wire logic sclk_in,
  input wire logic select_n_in,
  input wire logic [3:0] io_in,
  input wire logic [3:0] io_oe_in,
  input wire logic [1:0] pull_in,
  output logic [3:0] io_out
);
  import fbl_pkg::*;
  logic [7:0] img [256];
  logic [31:0] sh, crc;
  logic serving = 1'b0;
  logic mbit = 1'b0;
  logic stale = 1'b0;
  int bits, frame, dn, n_dn, n_up, n_drv, n_rd, k, j;

  // image with a valid little-endian checksum in its last four bytes
  initial
  begin
    crc = 32'hFFFFFFFF;
    for (k = 0; k < 252; k++)
    begin
      img[k] = 8'(k * 37 + 5);
      crc = crc ^ {img[k], 24'h000000};
      for (j = 0; j < 8; j++)
        crc = crc[31] ? (crc << 1) ^ 32'h04C11DB7 : crc << 1;
    end
    {img[255], img[254], img[253], img[252]} = crc;
  end

  // unpulled, undriven lines wander so a stale value never passes
  always @(sclk_in)
    stale = ~stale;

  always_comb
    for (int b = 0; b < 4; b++)
      io_out[b] = io_oe_in[b] ? io_in[b] : (b == 1 && serving) ? mbit :
        pull_in == PULL_UP ? 1'b1 : pull_in == PULL_DOWN ? 1'b0 : stale;

  always @(posedge rst_in)
  begin
    n_dn = 0;
    n_up = 0;
    n_drv = 0;
    n_rd = 0;
    frame = 0;
    bits = 0;
    serving = 1'b0;
  end

  always @(posedge select_n_in)
    if (!rst_in)
    begin
      frame++;
      bits = 0;
      serving = 1'b0;
    end

  always @(posedge sclk_in)
    if (!rst_in)
    begin
      // deselect may land on the last rise; count pulled-down clocks only
      if (select_n_in && pull_in == PULL_DOWN && io_out == 4'h0)
        n_dn++;
      if (!select_n_in && io_out == 4'hF && io_oe_in == 4'h0)
        n_up++;
      if (!select_n_in && frame == 1 && io_oe_in == 4'h1 && io_out[0])
        n_drv++;
      if (!select_n_in && bits < 32)
      begin
        sh = {sh[30:0], io_out[0]};
        bits++;
        // any other opcode, all-ones frames too, is ignored
        if (bits == 32 && sh == 32'h03000000)
        begin
          serving = 1'b1;
          dn = 0;
          n_rd++;
        end
      end
    end

  always @(negedge sclk_in)
    if (serving && dn < 2048)
    begin
      mbit = img[dn / 8][7 - dn % 8] ^ (corrupt_in && dn / 8 == 252);
      dn++;
    end
endmodule

// ---- dv/fbl_boot_loader_test.sv ----
// self-checking bench of the flash boot loader
// assumes the package and the flash model are compiled first
`timescale 1ns/1ps
module fbl_boot_loader_test;
  import fbl_pkg::*;
  // short attempts keep the fallback run near 70k cycles
  localparam int ACYC = 22000;
  localparam int NATT = 3;
  logic core_clk_in = 1'b0;
  logic clk_en_in = 1'b1;
  logic sys_rst_in, run_pin_in, osc_stable_in, rescue_flag_in;
  logic tie_low, corrupt, stage2_cfg_done_in, wake_event_in;
  logic fifo_in_valid_in, fifo_out_ready_in;
  logic [31:0] scratch4_in, scratch5_in, scratch6_in, scratch7_in;
  logic [31:0] fifo_in_data_in, fifo_out_data_out, core1_vector_table_offset_out;
  logic osc_start_out, subsys_release_out, rescue_clear_out, halt_out;
  logic scratch4_clear_out, wd_jump_out, usb_boot_out, pad_cfg_out;
  logic spi_std_mode_out, flash_sclk_out, flash_select_n_out, sram_we_out;
  logic exec_sram_out, xip_enable_out, fifo_in_ready_out;
  logic fifo_out_valid_out, deep_sleep_select_out, core1_run_out;
  logic [3:0] flash_io_lines_out, flash_io_lines_oe_out, flash_io_lines_in;
  logic [1:0] flash_io_pull_out;
  logic [7:0] sram_addr_out, sram_data_out;
  fbl_jump_t wd_target_out, core1_target_out;
  wire logic flash_select_n_in;
  int error_cnt = 0;
  int num_checks = 0;
  int i, n, wr, last;

  assign flash_select_n_in = tie_low ? 1'b0 : flash_select_n_out;

  always #2.5 core_clk_in = ~core_clk_in;

  fbl_boot_loader #(.ATTEMPT_CYCLES(ACYC), .ATTEMPTS(NATT)) i_fbl_boot_loader (
    .core_clk_in, .sys_rst_in, .clk_en_in, .run_pin_in, .osc_stable_in,
    .osc_start_out, .subsys_release_out, .rescue_flag_in, .rescue_clear_out,
    .halt_out, .scratch4_in, .scratch5_in, .scratch6_in, .scratch7_in,
    .scratch4_clear_out, .wd_jump_out, .wd_target_out, .usb_boot_out,
    .pad_cfg_out, .spi_std_mode_out, .flash_sclk_out, .flash_select_n_out,
    .flash_select_n_in, .flash_io_lines_out, .flash_io_lines_oe_out,
    .flash_io_lines_in, .flash_io_pull_out, .sram_we_out, .sram_addr_out,
    .sram_data_out, .exec_sram_out, .stage2_cfg_done_in, .xip_enable_out,
    .fifo_in_valid_in, .fifo_in_data_in, .fifo_in_ready_out,
    .fifo_out_valid_out, .fifo_out_data_out, .fifo_out_ready_in,
    .wake_event_in, .deep_sleep_select_out, .core1_run_out,
    .core1_vector_table_offset_out, .core1_target_out);

  fbl_flash_model i_fbl_flash_model (.rst_in(sys_rst_in),
    .corrupt_in(corrupt), .sclk_in(flash_sclk_out),
    .select_n_in(flash_select_n_out), .io_in(flash_io_lines_out),
    .io_oe_in(flash_io_lines_oe_out), .pull_in(flash_io_pull_out),
    .io_out(flash_io_lines_in));

  task automatic chk_flag(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: flag %b, want %b", $time, got, exp);
    end
  endtask

  task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: value %0h, want %0h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    if (error_cnt == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk_in);
    #1;
  endtask

  task automatic restart;
    sys_rst_in = 1'b1;
    cyc(4);
    sys_rst_in = 1'b0;
  endtask

  task automatic send(input logic [31:0] w);
    if (w == 32'h00000000)
    begin
      fifo_out_ready_in = 1'b1;
      cyc(2);
      wake_event_in = 1'b1;
      cyc(1);
      wake_event_in = 1'b0;
      chk_flag(deep_sleep_select_out, 1'b0);
    end
    fifo_out_ready_in = 1'b0;
    fifo_in_valid_in = 1'b1;
    fifo_in_data_in = w;
    for (n = 0; n < 20 && fifo_in_ready_out !== 1'b1; n++) cyc(1);
    cyc(1);
    fifo_in_valid_in = 1'b0;
    chk_flag(fifo_out_valid_out, 1'b1);
    chk_val(fifo_out_data_out, w);
    chk_flag(fifo_in_ready_out, 1'b0);
    fifo_out_ready_in = 1'b1;
    cyc(1);
    fifo_out_ready_in = 1'b0;
    // an edge between calls, so the next drain may raise ready again
    cyc(1);
  endtask

  task automatic launch;
    logic [31:0] seq [6];
    seq = '{32'h00000000, 32'h00000000, 32'h00000001, 32'h20000100,
      32'h20040000, 32'h10000201};
    send(32'h00000000);
    send(32'h00000007);
    for (i = 0; i < 6; i++)
    begin
      chk_flag(core1_run_out, 1'b0);
      send(seq[i]);
    end
    chk_flag(core1_run_out, 1'b1);
    chk_val(core1_vector_table_offset_out, seq[3]);
    chk_val(core1_target_out, {seq[4], seq[5]});
  endtask

  task automatic t_rescue;
    rescue_flag_in = 1'b1;
    restart();
    for (n = 0; n < 40 && halt_out !== 1'b1; n++) cyc(1);
    chk_flag(rescue_clear_out, 1'b1);
    chk_flag(subsys_release_out, 1'b1);
    cyc(1);
    chk_flag(rescue_clear_out, 1'b0);
    chk_flag(halt_out, 1'b1);
    chk_flag(pad_cfg_out, 1'b0);
    chk_flag(deep_sleep_select_out, 1'b1);
    launch();
    clk_en_in = 1'b0;
    run_pin_in = 1'b0;
    cyc(5);
    // frozen enable keeps all state, the low run pin included
    chk_flag(halt_out, 1'b1);
    clk_en_in = 1'b1;
    cyc(5);
    chk_flag(subsys_release_out, 1'b0);
    chk_flag(halt_out, 1'b0);
    chk_flag(osc_start_out, 1'b0);
    rescue_flag_in = 1'b0;
    run_pin_in = 1'b1;
  endtask

  task automatic t_warm;
    scratch4_in = 32'hB007C0D3;
    scratch6_in = 32'h20042000;
    scratch7_in = 32'h20001235;
    // one bit off in the second magic
    scratch5_in = scratch7_in ^ 32'hB007C0D2;
    osc_stable_in = 1'b0;
    restart();
    cyc(20);
    chk_flag(osc_start_out, 1'b1);
    chk_flag(subsys_release_out, 1'b0);
    osc_stable_in = 1'b1;
    for (n = 0; n < 20 && pad_cfg_out !== 1'b1; n++) cyc(1);
    chk_flag(subsys_release_out, 1'b1);
    chk_flag(wd_jump_out, 1'b0);
    chk_flag(spi_std_mode_out, 1'b1);
    scratch5_in = scratch7_in ^ 32'hB007C0D3;
    restart();
    for (n = 0; n < 20 && wd_jump_out !== 1'b1; n++) cyc(1);
    chk_flag(scratch4_clear_out, 1'b1);
    chk_val(wd_target_out, {scratch6_in, scratch7_in});
    cyc(1);
    chk_flag(scratch4_clear_out, 1'b0);
    chk_flag(wd_jump_out, 1'b1);
    chk_flag(pad_cfg_out, 1'b0);
    scratch4_in = 32'h00000000;
  endtask

  task automatic t_button;
    tie_low = 1'b1;
    restart();
    for (n = 0; n < 30 && usb_boot_out !== 1'b1; n++) cyc(1);
    chk_flag(usb_boot_out, 1'b1);
    chk_flag(pad_cfg_out, 1'b0);
    tie_low = 1'b0;
  endtask

  task automatic t_load;
    wr = 0;
    last = 0;
    restart();
    for (n = 0; n < ACYC && exec_sram_out !== 1'b1; n++)
    begin
      cyc(1);
      if (sram_we_out === 1'b1)
      begin
        chk_val(sram_addr_out, wr[7:0]);
        chk_val(sram_data_out, i_fbl_flash_model.img[wr]);
        wr++;
        last = n;
      end
    end
    chk_val(wr, 256);
    chk_flag(n - last <= 4, 1'b1);
    chk_val(i_fbl_flash_model.n_dn, 32);
    chk_val(i_fbl_flash_model.n_up, 32);
    chk_val(i_fbl_flash_model.n_drv, 16);
    chk_val(i_fbl_flash_model.n_rd, 1);
    cyc(20);
    chk_flag(xip_enable_out, 1'b0);
    stage2_cfg_done_in = 1'b1;
    cyc(3);
    chk_flag(xip_enable_out, 1'b1);
    stage2_cfg_done_in = 1'b0;
  endtask

  task automatic t_bad;
    corrupt = 1'b1;
    restart();
    for (n = 0; n < NATT * ACYC + 3000 && usb_boot_out !== 1'b1; n++) cyc(1);
    chk_flag(usb_boot_out, 1'b1);
    chk_flag(exec_sram_out, 1'b0);
    chk_val(i_fbl_flash_model.n_rd, NATT);
    chk_flag(n > (NATT - 1) * ACYC + 12000, 1'b1);
    corrupt = 1'b0;
  endtask

  initial
  begin
    run_pin_in = 1'b1;
    osc_stable_in = 1'b1;
    rescue_flag_in = 1'b0;
    tie_low = 1'b0;
    corrupt = 1'b0;
    stage2_cfg_done_in = 1'b0;
    wake_event_in = 1'b0;
    fifo_in_valid_in = 1'b0;
    fifo_out_ready_in = 1'b0;
    fifo_in_data_in = 32'h00000000;
    scratch4_in = 32'h00000000;
    scratch5_in = 32'h00000000;
    scratch6_in = 32'h00000000;
    scratch7_in = 32'h00000000;
    t_rescue();
    t_warm();
    t_button();
    t_load();
    t_bad();
    summarize();
  end

  // about 96k cycles, a fifth past the sum of all scenarios
  initial
  begin
    #480000;
    error_cnt++;
    summarize();
  end
endmodule
